/* gpa_pkg.sv */
// constants for the four-bit port with address output
// assumes a 32-bit avalon-mm slave with word addresses in bytes
package gpa_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PORT_W = 4;
   localparam logic [4:0] OFF_DIRECTION = 5'h00;
   localparam logic [4:0] OFF_OUTPUT_LATCH = 5'h04;
   localparam logic [4:0] OFF_PIN_READBACK = 5'h08;
   localparam logic [4:0] OFF_PULLUP = 5'h0C;
   localparam logic [4:0] OFF_OPENDRAIN = 5'h10;
   localparam logic [4:0] OFF_STANDBY = 5'h14;
   localparam int unsigned STB_ADDR_HOLD_BIT = 0;
   localparam int unsigned STB_SW_STANDBY_BIT = 1;
   localparam logic [3:0] PORT_RESET = 4'h0;
   localparam logic [1:0] STANDBY_RESET = 2'h0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam logic [2:0] MODE_4 = 3'h4;
   localparam logic [2:0] MODE_5 = 3'h5;
   localparam logic [2:0] MODE_6 = 3'h6;
   localparam logic [2:0] MODE_7 = 3'h7;
endpackage

/* gpa_port.sv */
// four-bit general purpose port with address output and avalon-mm registers
// assumes pins and mode inputs synchronous to clk_sys; pad resolves oe
`timescale 1ns/10ps
// What this block does
// - eight-bit read/write output latch register
// - upper nibble reserved, reads zero, writes ignored
// - latch clears on reset/hw standby, holds sw standby
// - readback register read-only, writes ignored
// - readback: latch if direction 1, else pin
// - readback frozen during software standby
// - pull-up bits effective only modes 6, 7
// - pull-up on: direction 0 and control 1
// - pull-up bits clear on reset/hw standby
// - open-drain drives low only, else releases
// - open-drain effective only in mode 7
// - open-drain bits clear on reset/hw standby
// - modes 4, 5: all pins address outputs
// - mode 6: direction 1 drives address
// - mode 7: direction 1 drives latch
// - direction write-only, clears on reset/hw standby
// - sw standby: address holds or floats per control
module gpa_port (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hw_standby,
   input wire logic [2:0] op_mode,
   input wire logic [gpa_pkg::PORT_W-1:0] addr_in,
   input wire logic [gpa_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [gpa_pkg::DATA_W-1:0] avs_writedata,
   output logic [gpa_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [gpa_pkg::PORT_W-1:0] pin_in,
   output logic [gpa_pkg::PORT_W-1:0] pin_out,
   output logic [gpa_pkg::PORT_W-1:0] pin_oe,
   output logic [gpa_pkg::PORT_W-1:0] pullup_en
);
   import gpa_pkg::*;

   typedef enum logic {GPA_IDLE, GPA_DONE} gpa_bus_e;

   logic [3:0] dir_reg, dir_next;
   logic [3:0] latch_reg, latch_next;
   logic [3:0] pullup_reg, pullup_next;
   logic [3:0] od_reg, od_next;
   logic [1:0] stb_reg, stb_next;
   logic [3:0] pin_smp_reg, pin_smp_next;
   logic [3:0] rb_reg, rb_next;
   logic [3:0] addr_hold_reg, addr_hold_next;
   logic [31:0] rdata_reg, rdata_next;
   gpa_bus_e bus_reg, bus_next;
   logic clr;
   logic sw_stby;
   logic wr_lo;
   logic req;
   logic mode_addr_all;
   logic mode_6;
   logic mode_7;

   assign clr = rst | hw_standby;
   assign sw_stby = stb_reg[STB_SW_STANDBY_BIT];
   assign req = avs_read | avs_write;
   // one wait state: access taken when waitrequest drops
   assign avs_waitrequest = req & (bus_reg == GPA_IDLE);
   assign wr_lo = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign mode_addr_all = (op_mode == MODE_4) | (op_mode == MODE_5);
   assign mode_6 = (op_mode == MODE_6);
   assign mode_7 = (op_mode == MODE_7);
   assign avs_readdata = rdata_reg;

   // register writes and state
   always_comb begin
      bus_next = (req && bus_reg == GPA_IDLE) ? GPA_DONE : GPA_IDLE;
      dir_next = dir_reg;
      latch_next = latch_reg;
      pullup_next = pullup_reg;
      od_next = od_reg;
      stb_next = stb_reg;
      if (wr_lo) begin
         case (avs_address)
            OFF_DIRECTION: dir_next = avs_writedata[3:0];
            OFF_OUTPUT_LATCH: latch_next = avs_writedata[3:0];
            OFF_PULLUP: pullup_next = avs_writedata[3:0];
            OFF_OPENDRAIN: od_next = avs_writedata[3:0];
            OFF_STANDBY: stb_next = avs_writedata[1:0];
            default: dir_next = dir_reg;
         endcase
      end
   end

   // clear on reset or hardware standby
   always_ff @(posedge clk_sys) begin
      if (clr) begin
         dir_reg <= PORT_RESET;
         latch_reg <= PORT_RESET;
         pullup_reg <= PORT_RESET;
         od_reg <= PORT_RESET;
         stb_reg <= STANDBY_RESET;
         bus_reg <= GPA_IDLE;
      end else begin
         dir_reg <= dir_next;
         latch_reg <= latch_next;
         pullup_reg <= pullup_next;
         od_reg <= od_next;
         stb_reg <= stb_next;
         bus_reg <= bus_next;
      end
   end

   // pin sampling, readback, address capture
   always_comb begin
      pin_smp_next = pin_in;
      rb_next = sw_stby ? rb_reg : ((dir_reg & latch_reg) | (~dir_reg & pin_smp_reg));
      addr_hold_next = sw_stby ? addr_hold_reg : addr_in;
      // read data must stand at the waitrequest-low edge, so it is latched in the wait cycle
      rdata_next = rdata_reg;
      if (avs_read && avs_waitrequest) begin
         case (avs_address)
            OFF_OUTPUT_LATCH: rdata_next = {28'h000_0000, latch_reg};
            OFF_PIN_READBACK: rdata_next = {28'h000_0000, rb_reg};
            OFF_PULLUP: rdata_next = {28'h000_0000, pullup_reg};
            OFF_OPENDRAIN: rdata_next = {28'h000_0000, od_reg};
            OFF_STANDBY: rdata_next = {30'h0000_0000, stb_reg};
            // direction reads zero since it is write-only
            default: rdata_next = UNMAPPED_READ;
         endcase
      end
   end

   // pin sample and address hold need no reset: they follow their inputs, address hold except in software standby
   always_ff @(posedge clk_sys) begin
      pin_smp_reg <= pin_smp_next;
      addr_hold_reg <= addr_hold_next;
      rdata_reg <= rst ? UNMAPPED_READ : rdata_next;
      rb_reg <= clr ? pin_smp_reg : rb_next;
   end

   // pin drive per bit
   genvar i;
   generate
      for (i = 0; i < PORT_W; i++) begin : g_pin
         logic is_addr;
         logic addr_val;
         logic addr_oe;
         assign is_addr = mode_addr_all | (mode_6 & dir_reg[i]);
         assign addr_val = sw_stby ? addr_hold_reg[i] : addr_in[i];
         assign addr_oe = ~sw_stby | stb_reg[STB_ADDR_HOLD_BIT];
         always_comb begin
            pin_out[i] = 1'b0;
            pin_oe[i] = 1'b0;
            if (is_addr) begin
               pin_out[i] = addr_val;
               pin_oe[i] = addr_oe;
            end else if (mode_7 && dir_reg[i]) begin
               pin_out[i] = latch_reg[i];
               pin_oe[i] = ~(od_reg[i] & latch_reg[i]);
            end
         end
         assign pullup_en[i] = (mode_6 | mode_7) & ~dir_reg[i] & pullup_reg[i];
      end
   endgenerate

   // address on pins in modes 4, 5
   addr_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_addr_all && !sw_stby) |-> (pin_oe == 4'hF && pin_out == addr_in))
      else $error("address mode pins wrong");
   gen_out_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_7 |-> ((pin_out & dir_reg) == (latch_reg & dir_reg)))
      else $error("general output mismatch");
   pullup_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_addr_all || (dir_reg != 4'h0)) |-> ((pullup_en & (dir_reg | {4{mode_addr_all}})) == 4'h0))
      else $error("pull-up on wrongly");
   od_high_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_7 |-> ((pin_oe & pin_out & od_reg & dir_reg) == 4'h0))
      else $error("open drain drove high");
   hw_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      hw_standby |=> (latch_reg == 4'h0 && dir_reg == 4'h0 && pullup_reg == 4'h0 && od_reg == 4'h0))
      else $error("hw standby did not clear");
   rb_freeze_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      (sw_stby && $past(sw_stby)) |-> $stable(rb_reg))
      else $error("readback changed in standby");
   rb_sel_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      (!sw_stby && $stable(dir_reg) && $stable(latch_reg)) |=>
      (sw_stby || ((rb_reg & $past(dir_reg)) == ($past(latch_reg) & $past(dir_reg)))))
      else $error("readback select wrong");
   bus_wait_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      ($rose(req) && bus_reg == GPA_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer timing wrong");

   // bus steps seen by the checks below
   sequence rd_wait_s;
      avs_read && avs_waitrequest;
   endsequence
   sequence wr_take_s;
      avs_write && !avs_waitrequest;
   endsequence

   rd_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
      rd_wait_s ##0 (avs_address == OFF_OUTPUT_LATCH) |=> (avs_readdata == {28'h000_0000, $past(latch_reg)}))
      else $error("latch read wrong");
   wr_latch_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      wr_take_s ##0 (avs_byteenable[0] && avs_address == OFF_OUTPUT_LATCH) |=>
      (latch_reg == $past(avs_writedata[3:0])))
      else $error("latch write lost");
   rd_back_a: assert property (@(posedge clk_sys) disable iff (rst)
      rd_wait_s ##0 (avs_address == OFF_PIN_READBACK) |=> (avs_readdata == {28'h000_0000, $past(rb_reg)}))
      else $error("readback read wrong");
   rd_pullup_a: assert property (@(posedge clk_sys) disable iff (rst)
      rd_wait_s ##0 (avs_address == OFF_PULLUP) |=> (avs_readdata == {28'h000_0000, $past(pullup_reg)}))
      else $error("pull-up read wrong");
   rd_od_a: assert property (@(posedge clk_sys) disable iff (rst)
      rd_wait_s ##0 (avs_address == OFF_OPENDRAIN) |=> (avs_readdata == {28'h000_0000, $past(od_reg)}))
      else $error("open-drain read wrong");
   rd_dir_a: assert property (@(posedge clk_sys) disable iff (rst)
      rd_wait_s ##0 (avs_address == OFF_DIRECTION) |=> (avs_readdata == UNMAPPED_READ))
      else $error("direction read not blank");
   wr_ro_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      wr_take_s ##0 (avs_address == OFF_PIN_READBACK) |=>
      ($stable(latch_reg) && $stable(dir_reg) && $stable(pullup_reg) && $stable(od_reg) && $stable(stb_reg)))
      else $error("readback write had effect");
   wr_mask_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      wr_take_s ##0 !avs_byteenable[0] |=>
      ($stable(latch_reg) && $stable(dir_reg) && $stable(pullup_reg) && $stable(od_reg) && $stable(stb_reg)))
      else $error("masked write had effect");
   sw_hold_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      (sw_stby && !avs_write) |=> ($stable(latch_reg) && $stable(dir_reg) && $stable(pullup_reg) && $stable(od_reg)))
      else $error("state lost in software standby");
   rst_clear_a: assert property (@(posedge clk_sys)
      rst |=> (latch_reg == 4'h0 && dir_reg == 4'h0 && pullup_reg == 4'h0 && od_reg == 4'h0))
      else $error("reset did not clear");
   pu_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
      !(mode_6 || mode_7) |-> (pullup_en == 4'h0))
      else $error("pull-up on in wrong mode");
   pu_on_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_6 || mode_7) |-> (pullup_en == (~dir_reg & pullup_reg)))
      else $error("pull-up gating wrong");
   od_cmos_a: assert property (@(posedge clk_sys) disable iff (rst)
      mode_7 |-> ((pin_oe & dir_reg & ~od_reg) == (dir_reg & ~od_reg)))
      else $error("cmos output not driven");
   // mode 6 address by direction, open-drain ignored
   m6_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_6 && !sw_stby) |-> (pin_oe == dir_reg && (pin_out & dir_reg) == (addr_in & dir_reg)))
      else $error("mode 6 pins wrong");
   in_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_6 || mode_7) |-> ((pin_oe & ~dir_reg) == 4'h0))
      else $error("input pin driven");
   addr_float_a: assert property (@(posedge clk_sys) disable iff (rst)
      (mode_addr_all && sw_stby && !stb_reg[STB_ADDR_HOLD_BIT]) |-> (pin_oe == 4'h0))
      else $error("address not released");
   addr_keep_a: assert property (@(posedge clk_sys) disable iff (rst || hw_standby)
      (mode_addr_all && $past(mode_addr_all) && sw_stby && $past(sw_stby)) |-> $stable(pin_out))
      else $error("held address moved");
   pin_smp_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> (pin_smp_reg == $past(pin_in)))
      else $error("pin sample lost");
   rb_clr_a: assert property (@(posedge clk_sys)
      clr |=> (rb_reg == $past(pin_smp_reg)))
      else $error("readback not from pins after clear");
endmodule // gpa_port

/* gpa_pad.sv */
// pad model: resolves port pins against an outside driver
// assumes oe high means the port drives the pin
`timescale 1ns/10ps
module gpa_pad (
   input wire logic clk_sys,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] pullup_en,
   input wire logic [3:0] ext_en,
   input wire logic [3:0] ext_val,
   output logic [3:0] pin_lvl
);
   logic [3:0] flt_reg;
   // a floating pin toggles so a stale level never reads as valid
   always @(posedge clk_sys) begin
      flt_reg <= (flt_reg === 4'h5) ? 4'hA : 4'h5;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pin_oe[i]) pin_lvl[i] = pin_out[i];
         else if (ext_en[i]) pin_lvl[i] = ext_val[i];
         else if (pullup_en[i]) pin_lvl[i] = 1'b1;
         else pin_lvl[i] = flt_reg[i];
      end
   end
endmodule // gpa_pad

/* tb.sv */
// bench for the four-bit port: register bus, pin modes, standby
// assumes gpa_pad resolves the pins; direction reads zero
`timescale 1ns/10ps
module tb;
   import gpa_pkg::*;
   typedef struct {logic [2:0] m; logic [3:0] d, l, o, p, oe, q, pu, rb;} gpa_row_s;
   logic clk_sys, rst, hw_standby, avs_read, avs_write, avs_waitrequest;
   logic [2:0] op_mode;
   logic [3:0] addr_in, avs_byteenable, pin_in, pin_out, pin_oe, pullup_en, ext_en, ext_val;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [4:0] offs [5] = '{OFF_DIRECTION, OFF_OUTPUT_LATCH, OFF_PULLUP, OFF_OPENDRAIN, 5'h18};
   gpa_row_s rows [6] = '{
      '{3'h4, 4'h0, 4'h3, 4'hF, 4'hF, 4'hF, 4'hC, 4'h0, 4'hC},
      '{3'h5, 4'h5, 4'h3, 4'hF, 4'hF, 4'hF, 4'hC, 4'h0, 4'h9},
      '{3'h6, 4'h5, 4'h3, 4'hF, 4'hF, 4'h5, 4'h4, 4'hA, 4'h3},
      '{3'h7, 4'h5, 4'h3, 4'h0, 4'h6, 4'h5, 4'h1, 4'h2, 4'h3},
      '{3'h7, 4'hF, 4'h3, 4'h6, 4'h0, 4'hD, 4'h1, 4'h0, 4'h3},
      '{3'h6, 4'hF, 4'h3, 4'h6, 4'hF, 4'hF, 4'hC, 4'h0, 4'h3}};
   int miscompares = 0;
   int n_checks = 0;
   gpa_port dut (.clk_sys(clk_sys), .rst(rst), .hw_standby(hw_standby), .op_mode(op_mode),
      .addr_in(addr_in), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pullup_en));
   gpa_pad pad (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));
   initial begin
      clk_sys = 0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   // request held until waitrequest is sampled low
   task automatic bus(logic w, logic [4:0] a, logic [31:0] d, logic [3:0] be);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      // a wait ends on waitrequest sampled low; only the watchdog ends one that never drops
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      @(posedge clk_sys);
   endtask
   initial begin
      #20000;
      miscompares++;
      end_of_test();
   end
   initial begin
      {rst, hw_standby, avs_read, avs_write, avs_address, avs_writedata} = '0;
      rst = 1;
      op_mode = 3'h7;
      {addr_in, ext_en, ext_val, avs_byteenable} = 16'h0000;
      repeat (3) @(posedge clk_sys);
      rst <= 0;
      @(posedge clk_sys);
      foreach (rows[i]) begin
         op_mode <= rows[i].m;
         addr_in <= ~rows[i].l;
         ext_en <= ~rows[i].d;
         ext_val <= 4'h6;
         bus(1, OFF_DIRECTION, 32'(rows[i].d), 4'hF);
         bus(1, OFF_OUTPUT_LATCH, 32'(rows[i].l), 4'hF);
         bus(1, OFF_OPENDRAIN, 32'(rows[i].o), 4'hF);
         bus(1, OFF_PULLUP, 32'(rows[i].p), 4'hF);
         repeat (3) @(posedge clk_sys);
         chk("pin_oe", 32'(rows[i].oe), 32'(pin_oe));
         chk("pin_out", 32'(rows[i].q), 32'(pin_out & pin_oe));
         chk("pullup_en", 32'(rows[i].pu), 32'(pullup_en));
         bus(0, OFF_PIN_READBACK, 32'h0000_0000, 4'hF);
         chk("pin_readback", 32'(rows[i].rb), rd);
         $display("row %0d done", i);
      end
      // reserved nibble, read-only readback, lane 0 off
      bus(1, OFF_OUTPUT_LATCH, 32'h0000_00FF, 4'hF);
      bus(0, OFF_OUTPUT_LATCH, 32'h0000_0000, 4'hF);
      chk("output_latch", 32'h0000_000F, rd);
      bus(1, OFF_PIN_READBACK, 32'h0000_0000, 4'hF);
      bus(0, OFF_PIN_READBACK, 32'h0000_0000, 4'hF);
      chk("pin_readback", 32'h0000_000F, rd);
      bus(1, OFF_OUTPUT_LATCH, 32'h0000_0003, 4'hE);
      bus(0, OFF_OUTPUT_LATCH, 32'h0000_0000, 4'hF);
      chk("output_latch", 32'h0000_000F, rd);
      $display("register access test done");
      op_mode <= 3'h7;
      ext_en <= 4'hF;
      bus(1, OFF_DIRECTION, 32'h0000_0000, 4'hF);
      bus(1, OFF_STANDBY, 32'h0000_0002, 4'hF);
      ext_val <= 4'h9;
      repeat (4) @(posedge clk_sys);
      bus(0, OFF_PIN_READBACK, 32'h0000_0000, 4'hF);
      chk("pin_readback", 32'h0000_0006, rd);
      bus(0, OFF_OUTPUT_LATCH, 32'h0000_0000, 4'hF);
      chk("output_latch", 32'h0000_000F, rd);
      op_mode <= 3'h4;
      repeat (2) @(posedge clk_sys);
      chk("pin_oe", 32'h0000_0000, 32'(pin_oe));
      // address moves while held: pins must keep the value from before standby
      addr_in <= 4'h3;
      bus(1, OFF_STANDBY, 32'h0000_0003, 4'hF);
      chk("pin_oe", 32'h0000_000F, 32'(pin_oe));
      chk("pin_out", 32'h0000_000C, 32'(pin_out));
      bus(1, OFF_STANDBY, 32'h0000_0000, 4'hF);
      $display("standby test done");
      op_mode <= 3'h7;
      // k 0 clears by hardware standby, k 1 by a mid-run reset
      for (int k = 0; k < 2; k++) begin
         foreach (offs[i]) bus(1, offs[i], 32'h0000_000F, 4'hF);
         hw_standby <= (k == 0);
         rst <= (k == 1);
         @(posedge clk_sys);
         {hw_standby, rst} <= 2'h0;
         @(posedge clk_sys);
         chk("pin_oe", 32'h0000_0000, 32'(pin_oe));
         foreach (offs[i]) begin
            bus(0, offs[i], 32'h0000_0000, 4'hF);
            chk("cleared_reg", 32'h0000_0000, rd);
         end
         $display("clear test %0d done", k);
      end
      end_of_test();
   end
endmodule // tb
